// ==== afc_ctrl.sv ====
`timescale 1ns/1ps
// Controller that drives the buffer pins from a simple register port
module afc_ctrl #(
  parameter int CNT_W = 4
) (
  // Clock and reset
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst_n,
  // Register port
  input  wire logic [3:0]           i_addr,
  input  wire logic [15:0]          i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [15:0]          o_rdata,
  // Buffer pins, outputs
  output logic                      o_reset_n_in,
  output logic                      o_write_n,
  output logic                      o_read_n,
  output logic                      o_first_load_or_rewind,
  output logic      [8:0]           o_write_data_in,
  output logic                      o_write_data_oe,
  // Buffer pins, inputs
  input  wire logic                 i_empty_flag_n,
  input  wire logic                 i_full_flag_n,
  input  wire logic                 i_chain_out_or_half_flag,
  input  wire logic [8:0]           i_read_data_out,
  // Mode strap seen at the buffer, single device when low
  output logic                      o_chain_in_n
);

  localparam int MAXC = afc_pkg::CYC_SETUP > afc_pkg::CYC_FLAG ?
                        afc_pkg::CYC_SETUP : afc_pkg::CYC_FLAG;

  // Elaboration check; the timer must hold the larger of the setup and flag counts
  if (MAXC >= (1 << CNT_W)) begin : g_width_check
    $error("afc_ctrl: CNT_W too small for timing counts");
  end

  afc_pkg::afc_state_e state_reg;
  afc_pkg::afc_state_e state_next;
  afc_pkg::afc_op_e    op_reg;
  afc_pkg::afc_pins_out_s pins_reg;
  afc_pkg::afc_pins_in_s  pins_in;

  logic [8:0]       wdata_reg;
  logic [8:0]       rdata_reg;
  logic [15:0]      rd_reg;
  logic             init_reg;
  logic             reject_reg;
  logic             tmr_load;
  logic [CNT_W-1:0] tmr_count;
  logic             tmr_done;
  logic [11:0]      flags_async;
  logic [11:0]      flags_sync;

  // Synchronise flags and read bus; flags idle as empty, not full, not half
  assign flags_async = {i_empty_flag_n, i_full_flag_n, i_chain_out_or_half_flag,
                        i_read_data_out};
  afc_sync #(.WIDTH(12)) u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async (flags_async),
    .i_init  (12'h600),
    .o_sync  (flags_sync)
  );
  assign pins_in = afc_pkg::afc_pins_in_s'(flags_sync);

  afc_timer #(.CNT_W(CNT_W)) u_timer (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_load  (tmr_load),
    .i_count (tmr_count),
    .o_done  (tmr_done)
  );

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction

  logic busy;
  logic cmd_wr;
  logic want_write;
  logic want_read;
  logic want_reset;
  logic want_rewind;
  assign busy        = (state_reg != afc_pkg::ST_IDLE);
  assign cmd_wr      = i_wr && (i_addr == afc_pkg::OFS_CTRL) && !busy;
  assign want_reset  = cmd_wr && i_wdata[afc_pkg::CMD_RESET_BIT];
  // Writer watches full, reader watches empty; write needs a prior reset
  assign want_write  = cmd_wr && i_wdata[afc_pkg::CMD_WRITE_BIT] && init_reg
                       && pins_in.full_flag_n;
  assign want_read   = cmd_wr && i_wdata[afc_pkg::CMD_READ_BIT]
                       && pins_in.empty_flag_n;
  assign want_rewind = cmd_wr && i_wdata[afc_pkg::CMD_REWIND_BIT] && init_reg;

  // Sequencer: each operation is setup, low pulse, high recovery, flag settle
  always_comb begin
    state_next = state_reg;
    tmr_load   = 1'b0;
    tmr_count  = cyc(afc_pkg::CYC_PULSE);
    unique case (state_reg)
      afc_pkg::ST_IDLE: begin
        if (want_reset || want_write || want_read || want_rewind) begin
          state_next = afc_pkg::ST_SETUP;
          tmr_load   = 1'b1;
          tmr_count  = cyc(afc_pkg::CYC_SETUP);
        end
      end
      afc_pkg::ST_SETUP: begin
        if (tmr_done) begin
          state_next = afc_pkg::ST_LOW;
          tmr_load   = 1'b1;
          tmr_count  = (op_reg == afc_pkg::OP_READ) ?
                       cyc(afc_pkg::CYC_ACCESS + 3) : cyc(afc_pkg::CYC_PULSE);
        end
      end
      afc_pkg::ST_LOW: begin
        if (tmr_done) begin
          state_next = afc_pkg::ST_HIGH;
          tmr_load   = 1'b1;
          tmr_count  = cyc(afc_pkg::CYC_RECOVER + 1);
        end
      end
      afc_pkg::ST_HIGH: begin
        if (tmr_done) begin
          state_next = afc_pkg::ST_SETTLE;
          tmr_load   = 1'b1;
          tmr_count  = cyc(afc_pkg::CYC_FLAG + 3);
        end
      end
      afc_pkg::ST_SETTLE: begin
        if (tmr_done) begin
          state_next = afc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = afc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= afc_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Latch the operation; reset wins when several bits are set
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      op_reg <= afc_pkg::OP_RESET;
    end else if (state_reg == afc_pkg::ST_IDLE) begin
      if (want_reset) begin
        op_reg <= afc_pkg::OP_RESET;
      end else if (want_rewind) begin
        op_reg <= afc_pkg::OP_REWIND;
      end else if (want_write) begin
        op_reg <= afc_pkg::OP_WRITE;
      end else if (want_read) begin
        op_reg <= afc_pkg::OP_READ;
      end
    end
  end

  // Pin drive; strobes stay high outside the low phase of their own operation
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pins_reg <= '{reset_n_in: 1'b1, write_n: 1'b1, read_n: 1'b1,
                    first_load_or_rewind: 1'b1, write_data_in: 9'h000,
                    write_data_oe: 1'b0};
    end else begin
      pins_reg.reset_n_in <= !(state_next == afc_pkg::ST_LOW
                               && op_reg == afc_pkg::OP_RESET);
      pins_reg.write_n <= !(state_next == afc_pkg::ST_LOW
                            && op_reg == afc_pkg::OP_WRITE);
      pins_reg.read_n <= !(state_next == afc_pkg::ST_LOW
                           && op_reg == afc_pkg::OP_READ);
      // Single-device mode only, so this pin is always the rewind strobe
      pins_reg.first_load_or_rewind <= !(state_next == afc_pkg::ST_LOW
                                         && op_reg == afc_pkg::OP_REWIND);
      // Data held through the whole write including recovery for hold time
      pins_reg.write_data_oe <= (state_next != afc_pkg::ST_IDLE)
                                && (op_reg == afc_pkg::OP_WRITE);
      pins_reg.write_data_in <= wdata_reg;
    end
  end

  // Command mode strap: single device; no chain handling offered
  assign o_chain_in_n = 1'b0;

  // Write data holding register
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wdata_reg <= 9'h000;
    end else if (i_wr && i_addr == afc_pkg::OFS_WDATA) begin
      wdata_reg <= i_wdata[8:0];
    end
  end

  // Capture read data just before raising the read strobe, while bus driven
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= afc_pkg::RDATA_RESET;
    end else if (state_reg == afc_pkg::ST_LOW && tmr_done
                 && op_reg == afc_pkg::OP_READ) begin
      rdata_reg <= pins_in.read_data_out;
    end
  end

  // Init flag set by a completed reset; reject flag marks a refused command
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      init_reg   <= 1'b0;
      reject_reg <= 1'b0;
    end else begin
      if (state_reg == afc_pkg::ST_SETTLE && tmr_done && op_reg == afc_pkg::OP_RESET) begin
        init_reg <= 1'b1;
      end
      if (cmd_wr && !(want_reset || want_write || want_read || want_rewind)) begin
        reject_reg <= 1'b1;
      end else if (cmd_wr) begin
        reject_reg <= 1'b0;
      end
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_reg <= 16'h0000;
    end else if (i_rd) begin
      unique case (i_addr)
        afc_pkg::OFS_STATUS: begin
          rd_reg <= {10'h000, reject_reg, init_reg,
                     !pins_in.chain_out_or_half_flag,
                     !pins_in.full_flag_n, !pins_in.empty_flag_n, busy};
        end
        afc_pkg::OFS_RDATA: begin
          rd_reg <= {7'h00, rdata_reg};
        end
        afc_pkg::OFS_WDATA: begin
          rd_reg <= {7'h00, wdata_reg};
        end
        default: begin
          rd_reg <= 16'h0000;
        end
      endcase
    end else begin
      rd_reg <= 16'h0000;
    end
  end

  assign o_rdata                = rd_reg;
  assign o_reset_n_in           = pins_reg.reset_n_in;
  assign o_write_n              = pins_reg.write_n;
  assign o_read_n               = pins_reg.read_n;
  assign o_first_load_or_rewind = pins_reg.first_load_or_rewind;
  assign o_write_data_in        = pins_reg.write_data_in;
  assign o_write_data_oe        = pins_reg.write_data_oe;

endmodule // afc_ctrl

// ==== afc_ctrl_checker.sv ====
`timescale 1ns/1ps
// Watches the pins that the controller drives towards the buffer
module afc_ctrl_checker #(
  parameter int CNT_W = 4
) (
  // Clock, reset and register port
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  input wire logic [3:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  // Buffer pins
  input wire logic        o_reset_n_in,
  input wire logic        o_write_n,
  input wire logic        o_read_n,
  input wire logic        o_first_load_or_rewind,
  input wire logic [8:0]  o_write_data_in,
  input wire logic        o_write_data_oe,
  input wire logic        i_empty_flag_n,
  input wire logic        i_full_flag_n,
  input wire logic        i_chain_out_or_half_flag,
  input wire logic [8:0]  i_read_data_out,
  input wire logic        o_chain_in_n
);
  logic seen_reset_reg;

  // Remembers a buffer reset; a write before one would hit random pointers
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) seen_reset_reg <= 1'b0;
    else if (!o_reset_n_in) seen_reset_reg <= 1'b1;
  end

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  chk_single_mode: assert property (o_chain_in_n == 1'b0)
    else $error("chain input not held low");
  chk_reset_first: assert property ($fell(o_write_n) |-> seen_reset_reg)
    else $error("write before any buffer reset");
  chk_reset_quiet: assert property ($rose(o_reset_n_in) |->
    $past(o_write_n && o_read_n, 5) && o_write_n && o_read_n ##1 o_write_n && o_read_n)
    else $error("strobes not high around reset release");
  chk_write_width: assert property ($fell(o_write_n) |-> !o_write_n[*5] ##1 o_write_n)
    else $error("write strobe width wrong");
  chk_read_width: assert property ($fell(o_read_n) |-> !o_read_n[*8] ##1 o_read_n)
    else $error("read strobe width wrong");
  chk_data_held: assert property ((!o_write_n || $rose(o_write_n)) |->
    o_write_data_oe && $stable(o_write_data_in))
    else $error("write data moved around the strobe");
  chk_rewind_quiet: assert property (!o_first_load_or_rewind |-> o_write_n && o_read_n)
    else $error("strobe active during rewind");
  chk_rewind_width: assert property ($fell(o_first_load_or_rewind) |->
    !o_first_load_or_rewind[*5] ##1 o_first_load_or_rewind)
    else $error("rewind pulse width wrong");
  chk_write_not_full: assert property ($fell(o_write_n) |-> $past(i_full_flag_n, 6))
    else $error("write started on a full buffer");
  chk_read_not_empty: assert property ($fell(o_read_n) |-> $past(i_empty_flag_n, 6))
    else $error("read started on an empty buffer");
endmodule // afc_ctrl_checker

// ==== afc_fifo_model.sv ====
`timescale 1ns/1ps
// Behavioural buffer: a ring of DEPTH words moved by strobe edges
module afc_fifo_model #(
  parameter int DEPTH = 256
) (
  // Strobes and controls
  input  wire logic       i_reset_n_in,
  input  wire logic       i_write_n,
  input  wire logic       i_read_n,
  input  wire logic       i_rewind_n,
  input  wire logic       i_chain_in_n,
  // Data and flags
  input  wire logic [8:0] i_write_data_in,
  input  wire logic       i_write_data_oe,
  output logic      [8:0] o_read_data_out,
  output logic            o_empty_flag_n,
  output logic            o_full_flag_n,
  output logic            o_half_full_flag_n
);
  logic [8:0] mem [DEPTH];
  logic [8:0] q = 9'h000;
  int         rp = 0;
  int         wp = 0;
  int         cnt = 0;
  bit         up = 0;
  bit         wok = 0;
  bit         rok = 0;

  // Reset puts both pointers at the first place
  always @(negedge i_reset_n_in) begin
    rp = 0;
    wp = 0;
    cnt = 0;
    up = 1;
  end
  // A write starts only after a reset and when not full
  always @(negedge i_write_n) wok = up && i_reset_n_in && cnt < DEPTH;
  // Word lands on the rising edge; undriven data is stored as unknown
  always @(posedge i_write_n) begin
    if (wok) begin
      mem[wp] = i_write_data_oe ? i_write_data_in : 9'bx;
      wp = (wp + 1) % DEPTH;
      cnt++;
    end
    wok = 0;
  end
  // A read starts only when not empty, oldest word first
  always @(negedge i_read_n) begin
    rok = cnt > 0;
    if (rok) q = mem[rp];
  end
  always @(posedge i_read_n) begin
    if (rok) begin
      rp = (rp + 1) % DEPTH;
      cnt--;
    end
    rok = 0;
  end
  // Rewind only in single mode; only valid with fewer than DEPTH writes
  always @(negedge i_rewind_n) begin
    if (!i_chain_in_n && i_reset_n_in) begin
      rp = 0;
      cnt = wp;
    end
  end
  // Flags follow the pending count; a released bus shows the inverted word
  assign o_empty_flag_n = (cnt - rok) != 0;
  assign o_full_flag_n = (cnt + wok) != DEPTH;
  // In chain mode the pin pulses low while the last location is written
  assign o_half_full_flag_n = i_chain_in_n ? !(wp == DEPTH - 1 && !i_write_n)
                                           : (cnt + wok) <= DEPTH / 2;
  assign o_read_data_out = i_read_n ? ~q : q;
endmodule // afc_fifo_model

// ==== afc_pkg.sv ====
// Behaviour
// - Controller pulses reset after power-up before any write.
// - Controller holds both strobes high around the rising reset edge.
// - Write starts at strobe fall only when not full; data held around rise.
// - Controller holds both strobes high during rewind.
// - In chain mode each chain input is wired to previous chain output.
// - Writer watches full, reader watches empty.
package afc_pkg;

  // Clock and pin timing, in ns as printed for the slowest grade
  localparam int CLK_PERIOD_NS  = 25;
  localparam int T_PULSE_NS     = 120;  // Strobe, reset and rewind low width
  localparam int T_RECOVER_NS   = 20;   // Strobe high recovery
  localparam int T_SETUP_NS     = 120;  // Strobe high before reset rise
  localparam int T_FLAG_NS      = 140;  // Longest flag settle time
  localparam int T_ACCESS_NS    = 120;  // Read data valid after strobe fall

  localparam int CYC_PULSE   = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_RECOVER = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_SETUP   = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_FLAG    = (T_FLAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_ACCESS  = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int DATA_W = 9;

  // Register offsets of the controller command port
  localparam logic [3:0] OFS_CTRL   = 4'h0;  // Write: command
  localparam logic [3:0] OFS_WDATA  = 4'h1;  // Write: data for next write
  localparam logic [3:0] OFS_STATUS = 4'h2;  // Read: flags and busy
  localparam logic [3:0] OFS_RDATA  = 4'h3;  // Read: last word read

  // Command field positions inside the control word
  localparam int CMD_RESET_BIT  = 0;
  localparam int CMD_WRITE_BIT  = 1;
  localparam int CMD_READ_BIT   = 2;
  localparam int CMD_REWIND_BIT = 3;

  // Status field positions
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_EMPTY_BIT  = 1;
  localparam int ST_FULL_BIT   = 2;
  localparam int ST_HALF_BIT   = 3;
  localparam int ST_INIT_BIT   = 4;
  localparam int ST_REJECT_BIT = 5;

  localparam logic [8:0] RDATA_RESET = 9'h000;

  // Pins that go to the buffer
  typedef struct packed {
    logic       reset_n_in;
    logic       write_n;
    logic       read_n;
    logic       first_load_or_rewind;
    logic [8:0] write_data_in;
    logic       write_data_oe;
  } afc_pins_out_s;

  // Synchronised pins from the buffer
  typedef struct packed {
    logic       empty_flag_n;
    logic       full_flag_n;
    logic       chain_out_or_half_flag;
    logic [8:0] read_data_out;
  } afc_pins_in_s;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_LOW    = 3'b010,
    ST_HIGH   = 3'b011,
    ST_SETTLE = 3'b100
  } afc_state_e;

  typedef enum logic [1:0] {
    OP_RESET  = 2'b00,
    OP_WRITE  = 2'b01,
    OP_READ   = 2'b10,
    OP_REWIND = 2'b11
  } afc_op_e;

endpackage

// ==== afc_sync.sv ====
`timescale 1ns/1ps
// Three-stage pin synchroniser; a change counts once stages two and three agree
module afc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  // Pin side
  input  wire logic [WIDTH-1:0] i_async,
  input  wire logic [WIDTH-1:0] i_init,
  // Clean side
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] held_reg;

  // Elaboration check; a zero-width chain has nothing to carry
  if (WIDTH < 1) begin : g_width_check
    $error("afc_sync: WIDTH must be at least 1");
  end

  // Shift chain; first stage feeds only the second
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Hold the agreed value per bit so glitches across one edge are dropped
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      held_reg <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          held_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  // Init value stands in for four edges, until the hold flop carries pin values
  logic [2:0] fill_reg;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fill_reg <= 3'h0;
    end else if (fill_reg != 3'h4) begin
      fill_reg <= fill_reg + 3'h1;
    end
  end

  assign o_sync = (fill_reg == 3'h4) ? held_reg : i_init;

endmodule // afc_sync

// ==== afc_timer.sv ====
`timescale 1ns/1ps
// Down-counter that gives a one-cycle done pulse after a loaded count
module afc_timer #(
  parameter int CNT_W = 4
) (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  // Control
  input  wire logic             i_load,
  input  wire logic [CNT_W-1:0] i_count,
  // Status
  output logic                  o_done
);

  logic [CNT_W-1:0] cnt_reg;
  logic             run_reg;

  // Elaboration check; a one-bit counter cannot hold the shortest phase
  if (CNT_W < 2) begin : g_width_check
    $error("afc_timer: CNT_W must be at least 2");
  end

  // Count down; done fires when the last cycle is reached
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end else if (i_load) begin
      cnt_reg <= i_count;
      run_reg <= 1'b1;
    end else if (run_reg) begin
      if (cnt_reg <= CNT_W'(1)) begin
        run_reg <= 1'b0;
      end
      cnt_reg <= cnt_reg - CNT_W'(1);
    end
  end

  assign o_done = run_reg && (cnt_reg <= CNT_W'(1));

endmodule // afc_timer

// ==== testbench.sv ====
`timescale 1ns/1ps
// Register port stimulus against the controller with a buffer model on its pins
module testbench;
  localparam int DEPTH = 8;
  localparam int LIMIT = 20000;
  localparam logic [15:0] C_RST = 16'h0001, C_WR = 16'h0002, C_RD = 16'h0004;
  localparam logic [15:0] C_RW = 16'h0008, EMP = 16'h0002, FUL = 16'h0004;
  localparam logic [15:0] HLF = 16'h0008, INI = 16'h0010, REJ = 16'h0020;
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  wire  [15:0] o_rdata;
  wire         rs_n, wr_n, rd_n, rw_n, oe, ch_n, ef_n, ff_n, hf_n;
  wire  [8:0]  wd, qd;
  logic [15:0] d;
  int          fails = 0;
  int          tests_run = 0;
  int          cyc = 0;

  always #12.5 i_mclk = ~i_mclk;

  afc_ctrl u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_reset_n_in(rs_n), .o_write_n(wr_n),
    .o_read_n(rd_n), .o_first_load_or_rewind(rw_n), .o_write_data_in(wd),
    .o_write_data_oe(oe), .i_empty_flag_n(ef_n), .i_full_flag_n(ff_n),
    .i_chain_out_or_half_flag(hf_n), .i_read_data_out(qd), .o_chain_in_n(ch_n));
  afc_fifo_model #(.DEPTH(DEPTH)) u_model (.i_reset_n_in(rs_n), .i_write_n(wr_n),
    .i_read_n(rd_n), .i_rewind_n(rw_n), .i_chain_in_n(ch_n), .i_write_data_in(wd),
    .i_write_data_oe(oe), .o_read_data_out(qd), .o_empty_flag_n(ef_n),
    .o_full_flag_n(ff_n), .o_half_full_flag_n(hf_n));

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Cuts a hung run short
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails++;
      finish_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bus cycles: one strobe cycle, then one idle edge so no strobe is set twice
  task automatic bus_wr(input logic [3:0] a, input logic [15:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  // Read data stand only in the cycle after the strobe; taken mid-cycle
  task automatic bus_rd(input logic [3:0] a, output logic [15:0] v);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    v = o_rdata;
    @(posedge i_mclk);
  endtask

  // Issues a command, then polls busy under a bound
  task automatic op(input logic [15:0] c);
    logic [15:0] s;
    int n;
    bus_wr(afc_pkg::OFS_CTRL, c);
    n = 0;
    do begin
      bus_rd(afc_pkg::OFS_STATUS, s);
      n++;
    end while (s[0] !== 1'b0 && n < 100);
    check({15'h0000, s[0]}, 16'h0000);
  endtask
  task automatic st(input logic [15:0] exp);
    logic [15:0] s;
    bus_rd(afc_pkg::OFS_STATUS, s);
    check(s & 16'h003E, exp);
  endtask
  task automatic push(input logic [8:0] v);
    bus_wr(afc_pkg::OFS_WDATA, {7'h00, v});
    op(C_WR);
  endtask
  task automatic pull(output logic [15:0] v);
    op(C_RD);
    bus_rd(afc_pkg::OFS_RDATA, v);
  endtask
  function automatic logic [8:0] pat(input int i);
    return 9'h155 ^ i[8:0];
  endfunction

  // Before a buffer reset: writes refused, odd address reads zero
  task automatic t_power_up();
    bus_rd(4'hF, d);
    check(d, 16'h0000);
    push(9'h0AA);
    bus_rd(afc_pkg::OFS_WDATA, d);
    check(d, 16'h00AA);
    st(EMP | REJ);
    check(16'(u_model.cnt), 16'h0000);
    op(C_RST);
    st(EMP | INI);
    check(16'(u_model.wp + u_model.rp), 16'h0000);
  endtask

  // Fill to full with flag checks after every word, then one more
  task automatic t_fill();
    for (int i = 0; i < DEPTH; i++) begin
      push(pat(i));
      st(INI | (i + 1 > DEPTH / 2 ? HLF : 16'h0000) | (i + 1 == DEPTH ? FUL : 16'h0000));
    end
    push(9'h1FF);
    st(INI | HLF | FUL | REJ);
    check(16'(u_model.wp), 16'h0000);
  endtask

  // Drain in order; full and half-full release, empty on the last word
  task automatic t_drain();
    for (int i = 0; i < DEPTH; i++) begin
      pull(d);
      check(d, {7'h00, pat(i)});
      st(INI | (DEPTH - 1 - i > DEPTH / 2 ? HLF : 16'h0000) | (i == DEPTH - 1 ? EMP : 16'h0000));
    end
    pull(d);
    check(d, {7'h00, pat(DEPTH - 1)});
    st(INI | EMP | REJ);
  endtask

  // Rewind after partial reads replays from the first word
  task automatic t_rewind();
    op(C_RST);
    for (int i = 0; i < DEPTH / 2 + 2; i++) begin
      push(pat(i + 3));
    end
    for (int i = 0; i < 3; i++) begin
      pull(d);
    end
    st(INI);
    op(C_RW);
    st(INI | HLF);
    pull(d);
    check(d, {7'h00, pat(3)});
    check(16'(u_model.wp), 16'(DEPTH / 2 + 2));
  endtask

  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (6) @(posedge i_mclk);
    t_power_up();
    t_fill();
    t_drain();
    t_rewind();
    finish_test();
  end
endmodule // testbench

bind afc_ctrl afc_ctrl_checker #(.CNT_W(CNT_W)) u_chk (.i_mclk, .i_rst_n, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .o_reset_n_in, .o_write_n, .o_read_n, .o_first_load_or_rewind,
  .o_write_data_in, .o_write_data_oe, .i_empty_flag_n, .i_full_flag_n,
  .i_chain_out_or_half_flag, .i_read_data_out, .o_chain_in_n);
